// file: verilog/gbwc_top.sv
`timescale 1ns/1ns
`include "gbwc_defines.svh"
// Notes on behaviour
// - Bitmap is 16384 words of 16 bits
// - Bitmap covers a 720 by 360 screen
// - Each modify cycle changes exactly one bit; none while bit3 fill is set
// - Pattern bits repeat 1 to 16 times
// - Unzoomed dots map one to one
// - Zoom blanks last dot of each block
// - Panning preshifts first word of each line
// - Data bus bits are negative true
// - Mode register loads on strobe five decode
// - Bit5 sample enable, bit4 display enable
// - Bit3 set/clear, bit2 pattern, bits1:0 JK
// - Pattern loads on strobe four, MSB first
// - Prescaler holds scale factor minus one
// - Display path runs from CLOCK, steps on dot clock rises
// - E,J,K select the written bit function
// - Pattern recirculates each time the prescaler reaches zero on a write, when enabled
module gbwc_top
   import gbwc_pkg::*;
#(
   parameter int WORDS = `GBWC_WORDS,
   parameter int ZOOM_W = 4
)
(
   input  wire logic        CLOCK,
   input  wire logic        SYS_RST,
   input  wire logic [6:0]  MUX_WORD_ADDR,
   input  wire logic [3:0]  BIT_SELECT,
   input  wire logic        RAS,
   input  wire logic        CAS,
   input  wire logic        WRITE_N,
   input  wire logic        DISPLAY_READ,
   input  wire logic [7:0]  TERMINAL_DATA_N,
   input  wire logic [2:0]  STROBE_FUNC,
   input  wire logic        PATTERN_SCALE_LOAD_STROBE_N,
   input  wire logic        PATTERN_INIT_STROBE_N,
   input  wire logic        MODE_LOAD_STROBE_N,
   input  wire logic        DOT_CLOCK,
   input  wire logic [3:0]  ZOOM_RATIO_M1,
   input  wire logic [3:0]  PAN_PRESHIFT,
   input  wire logic        LINE_START,
   input  wire logic        ZOOM_Y_LAST,
   output logic             SELECTED_BIT_READBACK,
   output logic             GRAPHICS_INHIBIT,
   output logic             SAMPLE,
   output logic             SERIAL_DOT
);
   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   localparam int SW = 7 + 4 + 1 + 1 + 1 + 1 + 8 + 3 + 3 + 1 + 1 + 1 + 4 + 4;
   logic [SW-1:0] raw_in;
   logic [SW-1:0] syn;
   assign raw_in = {MUX_WORD_ADDR, BIT_SELECT, RAS, CAS, WRITE_N,
                    DISPLAY_READ, TERMINAL_DATA_N, STROBE_FUNC,
                    PATTERN_SCALE_LOAD_STROBE_N, PATTERN_INIT_STROBE_N,
                    MODE_LOAD_STROBE_N, DOT_CLOCK, LINE_START,
                    ZOOM_Y_LAST, ZOOM_RATIO_M1, PAN_PRESHIFT};
   gbwc_sync #(.W(SW)) u_sync
   (
      .CLOCK   (CLOCK),
      .SYS_RST (SYS_RST),
      .d       (raw_in),
      .q       (syn)
   );
   logic [6:0] s_addr;
   logic [3:0] s_bit;
   logic       s_ras, s_cas, s_wr_n, s_dread, s_dclk, s_lstart, s_ylast;
   logic [7:0] s_data_n;
   logic [2:0] s_func;
   logic       s_pattern_scale_load_strobe_n, s_pattern_init_strobe_n, s_mode_load_strobe_n;
   logic [3:0] s_zoom, s_pan;
   assign {s_addr, s_bit, s_ras, s_cas, s_wr_n, s_dread, s_data_n,
           s_func, s_pattern_scale_load_strobe_n, s_pattern_init_strobe_n, s_mode_load_strobe_n, s_dclk, s_lstart,
           s_ylast, s_zoom, s_pan} = syn;

   // ------------------------------------------------------------------
   // Edge detection on synchronised levels
   // ------------------------------------------------------------------
   logic d_ras, d_cas, d_wr_n, d_pattern_scale_load_strobe_n, d_pattern_init_strobe_n, d_mode_load_strobe_n, d_dclk;
   logic d_lstart;
   // Previous levels; reset to the synchroniser's own reset value so
   // that release shows no false strobe or write edge
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         {d_ras, d_cas, d_dclk, d_lstart} <= 4'h0;
         {d_wr_n, d_pattern_scale_load_strobe_n, d_pattern_init_strobe_n, d_mode_load_strobe_n} <= 4'h0;
      end
      else
      begin
         {d_ras, d_cas, d_dclk, d_lstart} <= {s_ras, s_cas, s_dclk,
                                               s_lstart};
         {d_wr_n, d_pattern_scale_load_strobe_n, d_pattern_init_strobe_n, d_mode_load_strobe_n} <=
            {s_wr_n, s_pattern_scale_load_strobe_n, s_pattern_init_strobe_n, s_mode_load_strobe_n};
      end
   end
   logic ras_rise, cas_rise, wr_fall, dot_tick, line_go;
   logic pattern_scale_load_strobe_fall, pattern_init_strobe_fall, mode_load_strobe_fall;
   assign ras_rise  = s_ras & ~d_ras;
   assign cas_rise  = s_cas & ~d_cas;
   assign wr_fall   = ~s_wr_n & d_wr_n;
   assign pattern_scale_load_strobe_fall = ~s_pattern_scale_load_strobe_n & d_pattern_scale_load_strobe_n;
   assign pattern_init_strobe_fall = ~s_pattern_init_strobe_n & d_pattern_init_strobe_n;
   assign mode_load_strobe_fall = ~s_mode_load_strobe_n & d_mode_load_strobe_n;
   assign dot_tick  = s_dclk & ~d_dclk;
   assign line_go   = s_lstart & ~d_lstart;

   // ------------------------------------------------------------------
   // Strobe-decoded register bank
   // ------------------------------------------------------------------
   logic [7:0] bus_data;
   assign bus_data = ~s_data_n;
   logic [5:0] mode, next_mode;
   logic [7:0] pattern, next_pattern;
   logic [3:0] scale, next_scale, pcount, next_pcount;
   logic       fs_a0, fs_a5, fs_a6;
   assign fs_a0 = s_func[`GBWC_FS_A0];
   assign fs_a5 = s_func[`GBWC_FS_A5];
   assign fs_a6 = s_func[`GBWC_FS_A6];
   logic load_mode, load_pat, load_scale, pat_step;
   assign load_mode  = mode_load_strobe_fall & fs_a6 & ~fs_a5 & fs_a0;
   assign load_pat   = pattern_init_strobe_fall & fs_a6 & ~fs_a5 & ~fs_a0;
   assign load_scale = pattern_scale_load_strobe_fall & ~fs_a6 & fs_a5 & fs_a0;
   assign pat_step   = wr_fall & mode[`GBWC_MODE_SAMPLE] &
                       (pcount == 4'h0);

   // Register and prescaler next values
   always_comb
   begin
      next_mode    = mode;
      next_pattern = pattern;
      next_scale   = scale;
      next_pcount  = pcount;
      if (load_mode)
         next_mode = bus_data[5:0];
      if (load_scale)
         next_scale = bus_data[3:0];
      if (load_pat)
      begin
         next_pattern = bus_data;
         next_pcount  = scale;
      end
      else if (wr_fall & mode[`GBWC_MODE_SAMPLE])
      begin
         // Prescaler counts down, pattern moves on at zero
         next_pcount = (pcount == 4'h0) ? scale : pcount - 4'h1;
         if (pat_step)
            next_pattern = {pattern[6:0], pattern[7]};
      end
   end

   // Register bank
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         mode    <= `GBWC_MODE_RESET;
         pattern <= `GBWC_PATTERN_RESET;
         scale   <= `GBWC_SCALE_RESET;
         pcount  <= `GBWC_SCALE_RESET;
      end
      else
      begin
         mode    <= next_mode;
         pattern <= next_pattern;
         scale   <= next_scale;
         pcount  <= next_pcount;
      end
   end

   // ------------------------------------------------------------------
   // Display memory and read-modify-write
   // ------------------------------------------------------------------
   logic [`GBWC_WORD_BITS-1:0] mem [WORDS];
   logic [6:0]  row, next_row;
   logic [13:0] waddr;
   logic [13:0] clr_addr, next_clr_addr;
   assign waddr = {row, s_addr};
   logic [15:0] rword;
   assign rword = mem[waddr];
   logic old_bit, pat_bit, new_bit;
   assign old_bit = rword[s_bit];
   assign pat_bit = pattern[7];

   // Written-bit function
   function automatic logic alu(input gbwc_func_t f, input logic p,
                                input logic r);
      unique case (f)
         GBWC_KEEP:  alu = r;
         GBWC_CLEAR: alu = 1'b0;
         GBWC_SET:   alu = 1'b1;
         GBWC_COMPL: alu = ~r;
         GBWC_PAT:   alu = p;
         GBWC_PAND:  alu = p & r;
         GBWC_POR:   alu = p | r;
         GBWC_PXOR:  alu = p ^ r;
      endcase
   endfunction
   assign new_bit = alu(gbwc_func_t'(mode[2:0]), pat_bit, old_bit);

   logic do_write, do_fill;
   assign do_write = wr_fall & s_cas & ~mode[`GBWC_MODE_C];
   assign do_fill  = mode[`GBWC_MODE_C];
   always_comb
   begin
      next_row = ras_rise ? s_addr : row;
      next_clr_addr = do_fill ? clr_addr + 14'h1 : 14'h0;
   end
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         row      <= 7'h00;
         clr_addr <= 14'h0;
      end
      else
      begin
         row      <= next_row;
         clr_addr <= next_clr_addr;
      end
   end
   // Storage write port: one bit per cycle, or whole word in fill
   always_ff @(posedge CLOCK)
   begin
      if (do_fill)
         mem[clr_addr] <= {16{alu(gbwc_func_t'(mode[2:0]), pat_bit,
                                  1'b0)}};
      else if (do_write)
         mem[waddr][s_bit] <= new_bit;
   end

   // ------------------------------------------------------------------
   // Display shift path with zoom and pan
   // ------------------------------------------------------------------
   logic [15:0] shreg, next_shreg;
   logic [3:0]  zcnt, next_zcnt;
   logic        dot, next_dot;
   logic        readback, next_readback;
   // Next display values
   always_comb
   begin
      next_shreg = shreg;
      next_zcnt  = zcnt;
      next_dot   = dot;
      next_readback = cas_rise ? old_bit : readback;
      if (s_dread & cas_rise)
         // Load word; first word of a line is preshifted by pan
         next_shreg = line_go ? (rword >> s_pan) : rword;
      else if (dot_tick)
      begin
         // One dot per memory bit unzoomed, repeats when zoomed
         next_zcnt = (zcnt == s_zoom) ? 4'h0 : zcnt + 4'h1;
         if (zcnt == s_zoom)
            next_shreg = {1'b0, shreg[15:1]};
         // Last dot of each zoom block is blanked in X and Y
         next_dot = shreg[0] & mode[`GBWC_MODE_H] & ~s_ylast &
                    ~((s_zoom != 4'h0) & (zcnt == s_zoom));
      end
      // Inhibited display drops a lit dot at once
      if (!mode[`GBWC_MODE_H])
         next_dot = 1'b0;
   end
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         shreg    <= 16'h0000;
         zcnt     <= 4'h0;
         dot      <= 1'b0;
         readback <= 1'b0;
      end
      else
      begin
         shreg    <= next_shreg;
         zcnt     <= next_zcnt;
         dot      <= next_dot;
         readback <= next_readback;
      end
   end
   assign SERIAL_DOT            = dot;
   assign SELECTED_BIT_READBACK = readback;
   assign GRAPHICS_INHIBIT      = ~mode[`GBWC_MODE_H];
   assign SAMPLE                = mode[`GBWC_MODE_SAMPLE];

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_mode_load;
      @(posedge CLOCK) disable iff (SYS_RST)
      load_mode |=> (mode == $past(bus_data[5:0]));
   endproperty
   a_mode_load: assert property (p_mode_load)
      else $error("mode register did not load");
   property p_sample_out;
      @(posedge CLOCK) disable iff (SYS_RST)
      load_mode |=> (SAMPLE == $past(bus_data[5]));
   endproperty
   a_sample_out: assert property (p_sample_out)
      else $error("sample output wrong");
   property p_pat_load;
      @(posedge CLOCK) disable iff (SYS_RST)
      load_pat |=> (pattern == ~$past(s_data_n)) && (pcount == $past(scale));
   endproperty
   a_pat_load: assert property (p_pat_load)
      else $error("pattern load wrong");
   property p_scale_load;
      @(posedge CLOCK) disable iff (SYS_RST)
      load_scale && !load_pat |=> scale == $past(bus_data[3:0]);
   endproperty
   a_scale_load: assert property (p_scale_load)
      else $error("prescaler load wrong");
   property p_pat_hold;
      @(posedge CLOCK) disable iff (SYS_RST)
      !mode[`GBWC_MODE_SAMPLE] && !load_pat |=> $stable(pattern);
   endproperty
   a_pat_hold: assert property (p_pat_hold)
      else $error("pattern moved without sample");
   property p_pat_rot;
      @(posedge CLOCK) disable iff (SYS_RST)
      pat_step && !load_pat |=> pattern == {$past(pattern[6:0]),
                                             $past(pattern[7])};
   endproperty
   a_pat_rot: assert property (p_pat_rot)
      else $error("pattern did not rotate");
   property p_inhibit;
      @(posedge CLOCK) disable iff (SYS_RST)
      GRAPHICS_INHIBIT |=> !dot;
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("dot shown while inhibited");
   property p_readback;
      @(posedge CLOCK) disable iff (SYS_RST)
      cas_rise |=> SELECTED_BIT_READBACK == $past(old_bit);
   endproperty
   a_readback: assert property (p_readback)
      else $error("readback wrong");
   c_mode: cover property (@(posedge CLOCK) load_mode);
   c_write: cover property (@(posedge CLOCK) do_write);
   c_step: cover property (@(posedge CLOCK) pat_step);
endmodule

// file: common/gbwc_defines.svh
`ifndef GBWC_DEFINES_SVH
`define GBWC_DEFINES_SVH
// ----------------------------------------------------------------------
// Memory geometry
// ----------------------------------------------------------------------
`define GBWC_WORDS        16384
`define GBWC_WORD_BITS    16
`define GBWC_ADDR_BITS    14
`define GBWC_SCREEN_X     720
`define GBWC_SCREEN_Y     360
`define GBWC_WORDS_PER_LINE 45
// ----------------------------------------------------------------------
// Mode control field positions
// ----------------------------------------------------------------------
`define GBWC_MODE_K       0
`define GBWC_MODE_J       1
`define GBWC_MODE_E       2
`define GBWC_MODE_C       3
`define GBWC_MODE_H       4
`define GBWC_MODE_SAMPLE  5
`define GBWC_MODE_RESET   6'h00
`define GBWC_PATTERN_RESET 8'h00
`define GBWC_SCALE_RESET  4'h0
// ----------------------------------------------------------------------
// Strobe function specifier positions in the strobe address
// ----------------------------------------------------------------------
`define GBWC_FS_A0        0
`define GBWC_FS_A5        1
`define GBWC_FS_A6        2
`endif

// file: common/gbwc_pkg.sv
package gbwc_pkg;
   // ALU function selected by E, J, K
   typedef enum logic [2:0]
   {
      GBWC_KEEP   = 3'b000,
      GBWC_CLEAR  = 3'b001,
      GBWC_SET    = 3'b010,
      GBWC_COMPL  = 3'b011,
      GBWC_PAT    = 3'b100,
      GBWC_PAND   = 3'b101,
      GBWC_POR    = 3'b110,
      GBWC_PXOR   = 3'b111
   } gbwc_func_t;
   // Memory cycle sequencer state
   typedef enum logic [1:0]
   {
      GBWC_IDLE  = 2'b00,
      GBWC_ROW   = 2'b01,
      GBWC_COL   = 2'b10
   } gbwc_state_t;
endpackage

// file: verilog/gbwc_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for a group of pin levels
module gbwc_sync
#(
   parameter int W = 1
)
(
   input  wire logic         CLOCK,
   input  wire logic         SYS_RST,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   // Next values
   always_comb
   begin
      next_meta = d;
      next_q    = meta;
   end

   // Registers
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= next_meta;
         q    <= next_q;
      end
   end
endmodule

// file: test/gbwc_ctrl_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Memory controller model on the terminal and memory buses
// ----------------------------------------------------------------------
module gbwc_ctrl_model
(
   input  wire logic       CLOCK,
   input  wire logic       SELECTED_BIT_READBACK,
   output logic      [6:0] MUX_WORD_ADDR,
   output logic      [3:0] BIT_SELECT,
   output logic            RAS,
   output logic            CAS,
   output logic            WRITE_N,
   output logic            DISPLAY_READ,
   output logic      [7:0] TERMINAL_DATA_N,
   output logic      [2:0] STROBE_FUNC,
   output logic      [2:0] STROBE_N
);
   // Idle levels: data bus released to its pull-up, strobes high
   initial
   begin
      MUX_WORD_ADDR = 7'h00;
      BIT_SELECT = 4'h0;
      RAS = 1'b0;
      CAS = 1'b0;
      WRITE_N = 1'b1;
      DISPLAY_READ = 1'b0;
      TERMINAL_DATA_N = 8'hff;
      STROBE_FUNC = 3'h0;
      STROBE_N = 3'h7;
   end

   // Step to just after a later rising edge
   task automatic wt(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask

   // Strobe-decoded load; sel 0 scale, 1 pattern, 2 mode
   task automatic strobe(input int sel, input logic [2:0] func,
                         input logic [7:0] data);
      wt(1);
      STROBE_FUNC = func;
      TERMINAL_DATA_N = ~data;
      wt(3);
      STROBE_N[sel] = 1'b0;
      wt(5);
      STROBE_N[sel] = 1'b1;
      wt(4);
      TERMINAL_DATA_N = 8'hff;
   endtask

   // Row then column cycle, one-bit write or display load inside
   task automatic access(input logic [13:0] addr, input logic [3:0] bit_no,
                         input logic wr, input logic disp,
                         output logic rd);
      wt(1);
      MUX_WORD_ADDR = addr[13:7];
      BIT_SELECT = bit_no;
      DISPLAY_READ = disp;
      wt(3);
      RAS = 1'b1;
      wt(3);
      MUX_WORD_ADDR = addr[6:0];
      wt(3);
      CAS = 1'b1;
      wt(5);
      rd = SELECTED_BIT_READBACK;
      if (wr)
      begin
         WRITE_N = 1'b0;
         wt(3);
         WRITE_N = 1'b1;
         wt(3);
      end
      CAS = 1'b0;
      RAS = 1'b0;
      DISPLAY_READ = 1'b0;
      wt(3);
      MUX_WORD_ADDR = ~addr[6:0];
   endtask
endmodule

// file: test/tb_graphics_bitmap_write_control.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Bench for the bitmap write control front end
// ----------------------------------------------------------------------
module tb_graphics_bitmap_write_control
   import gbwc_pkg::*;
;
   logic       clock;
   logic       sys_rst;
   logic [6:0] mux_word_addr;
   logic [3:0] bit_select;
   logic       ras;
   logic       cas;
   logic       write_n;
   logic       display_read;
   logic [7:0] terminal_data_n;
   logic [2:0] strobe_func;
   logic [2:0] strobe_n;
   logic       dot_clock;
   logic [3:0] zoom_ratio_m1;
   logic [3:0] pan_preshift;
   logic       line_start;
   logic       zoom_y_last;
   logic       selected_bit_readback;
   logic       graphics_inhibit;
   logic       sample;
   logic       serial_dot;
   logic       rd;
   logic [5:0] r;
   logic [13:0] a;
   int         n_errors = 0;
   int         n_checks = 0;
   // Pattern byte for the stretch test, bit 7 written first
   localparam logic [7:0] PAT_EXP = 8'hb4;
   // Rows: function, pattern bit, old bit, expected new bit
   localparam logic [5:0] ROWS [14] = '{
      {GBWC_KEEP, 3'b011}, {GBWC_KEEP, 3'b000}, {GBWC_CLEAR, 3'b010},
      {GBWC_SET, 3'b001}, {GBWC_COMPL, 3'b010}, {GBWC_COMPL, 3'b001},
      {GBWC_PAT, 3'b101}, {GBWC_PAT, 3'b010}, {GBWC_PAND, 3'b111},
      {GBWC_PAND, 3'b010}, {GBWC_POR, 3'b101}, {GBWC_POR, 3'b000},
      {GBWC_PXOR, 3'b110}, {GBWC_PXOR, 3'b011}};

   gbwc_top #(.WORDS(16384), .ZOOM_W(4)) i_gbwc_top
   (
      .CLOCK                       (clock),
      .SYS_RST                     (sys_rst),
      .MUX_WORD_ADDR               (mux_word_addr),
      .BIT_SELECT                  (bit_select),
      .RAS                         (ras),
      .CAS                         (cas),
      .WRITE_N                     (write_n),
      .DISPLAY_READ                (display_read),
      .TERMINAL_DATA_N             (terminal_data_n),
      .STROBE_FUNC                 (strobe_func),
      .PATTERN_SCALE_LOAD_STROBE_N (strobe_n[0]),
      .PATTERN_INIT_STROBE_N       (strobe_n[1]),
      .MODE_LOAD_STROBE_N          (strobe_n[2]),
      .DOT_CLOCK                   (dot_clock),
      .ZOOM_RATIO_M1               (zoom_ratio_m1),
      .PAN_PRESHIFT                (pan_preshift),
      .LINE_START                  (line_start),
      .ZOOM_Y_LAST                 (zoom_y_last),
      .SELECTED_BIT_READBACK       (selected_bit_readback),
      .GRAPHICS_INHIBIT            (graphics_inhibit),
      .SAMPLE                      (sample),
      .SERIAL_DOT                  (serial_dot)
   );

   gbwc_ctrl_model i_gbwc_ctrl_model
   (
      .CLOCK                 (clock),
      .SELECTED_BIT_READBACK (selected_bit_readback),
      .MUX_WORD_ADDR         (mux_word_addr),
      .BIT_SELECT            (bit_select),
      .RAS                   (ras),
      .CAS                   (cas),
      .WRITE_N               (write_n),
      .DISPLAY_READ          (display_read),
      .TERMINAL_DATA_N       (terminal_data_n),
      .STROBE_FUNC           (strobe_func),
      .STROBE_N              (strobe_n)
   );

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic check(input logic seen, input logic exp, input string m);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: %s saw %b want %b", $time, m, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic mode(input logic [7:0] d);
      i_gbwc_ctrl_model.strobe(2, 3'b101, d);
   endtask

   // Load a word for display, then count lit dots over eight dot clocks
   task automatic show(input logic [3:0] zm, input logic yl,
                       input logic [7:0] md, input int exp);
      int ones;
      ones = 0;
      zoom_ratio_m1 = zm;
      zoom_y_last = yl;
      mode(md);
      i_gbwc_ctrl_model.access(14'h3000, 4'h0, 1'b0, 1'b1, rd);
      // Line start rises with the column strobe of the first word
      fork
         i_gbwc_ctrl_model.access(14'h3001, 4'h0, 1'b0, 1'b1, rd);
         begin
            repeat (10) @(posedge clock);
            #1 line_start = 1'b1;
            repeat (3) @(posedge clock);
            #1 line_start = 1'b0;
         end
      join
      for (int i = 0; i < 10; i++)
      begin
         if (i >= 2 && serial_dot === 1'b1)
            ones++;
         #40 dot_clock = 1'b1;
         #40 dot_clock = 1'b0;
      end
      check(ones == exp, 1'b1, "dot count");
   endtask

   // Free-running system clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Watchdog against a hung handshake
   initial
   begin
      #400000;
      n_errors++;
      stop_test();
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      sys_rst = 1'b1;
      dot_clock = 1'b0;
      zoom_ratio_m1 = 4'h0;
      pan_preshift = 4'h0;
      line_start = 1'b0;
      zoom_y_last = 1'b0;
      repeat (2) @(posedge clock);
      #1 sys_rst = 1'b0;
      check(graphics_inhibit, 1'b1, "reset inhibit");
      check(sample, 1'b0, "reset sample");
      check(serial_dot, 1'b0, "reset dot");
      repeat (4) @(posedge clock);
      // Whole-memory set, then probe words 0, 8191 and 16382
      mode(8'h1a);
      repeat (16400) @(posedge clock);
      mode(8'h10);
      for (int i = 0; i < 3; i++)
      begin
         i_gbwc_ctrl_model.access(14'(i * 8191), 4'(i * 7), 1'b0, 1'b0, rd);
         check(rd, 1'b1, "fill");
      end
      show(4'h0, 1'b0, 8'h10, 8);
      show(4'h0, 1'b0, 8'h00, 0);
      show(4'h1, 1'b0, 8'h10, 4);
      show(4'h1, 1'b1, 8'h10, 0);
      // First word shifted right by nine leaves seven lit bits
      pan_preshift = 4'h9;
      show(4'h0, 1'b0, 8'h10, 6);
      pan_preshift = 4'h0;
      // Every write function from a preset old bit
      for (int i = 0; i < 14; i++)
      begin
         r = ROWS[i];
         a = 14'h0100 + 14'(i);
         mode(r[1] ? 8'h12 : 8'h11);
         i_gbwc_ctrl_model.access(a, 4'(i), 1'b1, 1'b0, rd);
         i_gbwc_ctrl_model.strobe(1, 3'b100, r[2] ? 8'h80 : 8'h00);
         mode({4'b0001, 1'b0, r[5:3]});
         check(graphics_inhibit, 1'b0, "display on");
         i_gbwc_ctrl_model.access(a, 4'(i), 1'b1, 1'b0, rd);
         i_gbwc_ctrl_model.access(a, 4'(i), 1'b0, 1'b0, rd);
         check(rd, r[0], "write function");
      end
      // Pattern stretched by two, bit 7 first
      i_gbwc_ctrl_model.strobe(0, 3'b011, 8'hf1);
      i_gbwc_ctrl_model.strobe(1, 3'b100, PAT_EXP);
      mode(8'h34);
      check(sample, 1'b1, "sample set");
      for (int i = 0; i < 16; i++)
         i_gbwc_ctrl_model.access(14'h2abc, 4'(i), 1'b1, 1'b0, rd);
      for (int i = 0; i < 16; i++)
      begin
         i_gbwc_ctrl_model.access(14'h2abc, 4'(i), 1'b0, 1'b0, rd);
         check(rd, PAT_EXP[7 - i / 2], "stretch");
      end
      // Mode strobe with a wrong function field is ignored
      i_gbwc_ctrl_model.strobe(2, 3'b100, 8'h00);
      check(sample, 1'b1, "wrong decode");
      // Reset in mid-run clears the mode register
      @(posedge clock);
      #1 sys_rst = 1'b1;
      repeat (2) @(posedge clock);
      #1 sys_rst = 1'b0;
      check(sample, 1'b0, "rerun sample");
      check(graphics_inhibit, 1'b1, "rerun inhibit");
      stop_test();
   end
endmodule
